/* File: core/voltage_code_regs.sv */
/*
  voltage-code register bank: converter alternate target code and first
  linear regulator code, with their decoders and the scaling target select.
  assumes register requests arrive synchronous to mclk_i from the device's
  serial control engine, and that the normal converter code and the
  scaling select bit come from the neighbouring timing/normal registers.
*/
// Overview of operation
// - alternate converter code at 0x41, read/write
// - alternate converter code resets to 0x30
// - one shared decoder for both converter codes
// - code zero 0.6 V, 12.5 mV per step
// - codes 0xD8 and above clamp at 3.3 V
// - linear regulator one code at 0x42, read/write
// - linear regulator one code resets to 0x10
// - code in bits 5..0, spares read zero
// - select bit picks normal or alternate code
// - linear decoder 1.0 V, 50 mV, clamp 0x2E
`timescale 1ns/1ps
`default_nettype none
module voltage_code_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port from the serial control engine
  input wire voltage_code_pkg::reg_req_t req_i,
  output var voltage_code_pkg::reg_rsp_t rsp_o,
  // neighbouring converter controls
  input wire logic [7:0] converter_normal_voltage_code_i,
  input wire logic dynamic_voltage_scaling_sel_i,
  // decoded regulator targets
  output logic [15:0] converter_target_dmv_o,
  output logic [15:0] linreg1_target_mv_o
);
  import voltage_code_pkg::*;

  logic [7:0] alt_code_q;       // converter alternate target code
  logic [LIN_CODE_W-1:0] lin1_code_q; // linear regulator one code field
  logic [7:0] lin1_reg;         // full linear register view
  reg_rsp_t rsp_q;              // read answer
  logic [15:0] conv_tgt_q;      // decoded converter target
  logic [15:0] lin_tgt_q;       // decoded linear target
  logic [7:0] active_code;      // code chosen by the select bit
  logic init_done_q;            // low only until the first edge after reset

  // spare bits are constant zero in the visible register
  assign lin1_reg = {LIN_SPARE_VALUE, lin1_code_q};

  // alternate converter code register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alt_code_q <= ALT_CODE_RESET;
    end else if (req_i.wr && req_i.addr == ALT_CODE_ADDR) begin
      alt_code_q <= req_i.wdata;
    end
  end

  // linear regulator one code register; only the code field is stored
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lin1_code_q <= LIN1_CODE_RESET[LIN_CODE_MSB:0];
    end else if (req_i.wr && req_i.addr == LIN1_CODE_ADDR) begin
      lin1_code_q <= req_i.wdata[LIN_CODE_MSB:0];
    end
  end

  // read path: one cycle after the strobe, unmapped offsets read zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= req_i.rd;
      // mapped offsets show stored state
      if (req_i.rd && req_i.addr == ALT_CODE_ADDR) begin
        rsp_q.data <= alt_code_q;
      end else if (req_i.rd && req_i.addr == LIN1_CODE_ADDR) begin
        rsp_q.data <= lin1_reg;
      end else begin
        rsp_q.data <= READ_ZERO;
      end
    end
  end
  assign rsp_o = rsp_q;

  // target selection between normal and alternate codes
  always_comb begin
    active_code = dynamic_voltage_scaling_sel_i ? alt_code_q
                                                : converter_normal_voltage_code_i;
  end

  // decoded targets, registered
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_tgt_q <= '0;
      lin_tgt_q <= '0;
    end else begin
      conv_tgt_q <= conv_decode(active_code);
      lin_tgt_q <= lin_decode(lin1_code_q);
    end
  end
  assign converter_target_dmv_o = conv_tgt_q;
  assign linreg1_target_mv_o = lin_tgt_q;

  // marks the first clock edge after reset release
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  // checks
  sequence s_alt_write;
    req_i.wr && req_i.addr == ALT_CODE_ADDR;
  endsequence
  sequence s_alt_read;
    req_i.rd && req_i.addr == ALT_CODE_ADDR && !req_i.wr;
  endsequence

  a_alt_reset_value: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !init_done_q |-> alt_code_q == ALT_CODE_RESET && lin1_reg == LIN1_CODE_RESET)
    else $error("reset codes wrong");
  a_lin_reset_value: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !init_done_q && !req_i.wr |=> lin1_reg == LIN1_CODE_RESET)
    else $error("linear reset code wrong");
  a_alt_write_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_alt_write ##1 s_alt_read |=> rsp_o.valid && rsp_o.data == $past(req_i.wdata, 2))
    else $error("alternate code readback mismatch");
  a_lin_write_field: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_i.wr && req_i.addr == LIN1_CODE_ADDR |=> lin1_reg == {2'h0, $past(req_i.wdata[5:0])})
    else $error("linear code write wrong");
  a_lin_spare_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rsp_o.valid && $past(req_i.addr) == LIN1_CODE_ADDR |-> rsp_o.data[7:6] == 2'h0)
    else $error("spare bits read nonzero");
  a_spare_write_ignored: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_i.wr && req_i.addr == LIN1_CODE_ADDR && req_i.wdata[7:6] != 2'h0 |=> lin1_reg[7:6] == 2'h0)
    else $error("spare write stored");
  a_conv_code_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_code == 8'h00 |=> converter_target_dmv_o == 16'h1770)
    else $error("code zero not 0.6 V");
  a_conv_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_code == 8'h01 |=> converter_target_dmv_o == 16'h17ED)
    else $error("code one not 0.6125 V");
  a_conv_clamp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_code >= 8'hD8 |=> converter_target_dmv_o == 16'h80E8)
    else $error("converter clamp wrong");
  a_conv_below_clamp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_code == 8'hD7 |=> converter_target_dmv_o == 16'h806B)
    else $error("code D7 not 3.2875 V");
  a_sel_picks_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ##1 $past(dynamic_voltage_scaling_sel_i) && $stable(alt_code_q) |->
      converter_target_dmv_o == conv_decode($past(alt_code_q)))
    else $error("alternate code not selected");
  a_sel_normal: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !dynamic_voltage_scaling_sel_i && converter_normal_voltage_code_i == 8'h30
      |=> converter_target_dmv_o == 16'h2EE0)
    else $error("normal code not selected");
  a_lin_clamp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    lin1_code_q >= 6'h2E |=> linreg1_target_mv_o == 16'h0CE4)
    else $error("linear clamp wrong");
  a_lin_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    lin1_code_q == 6'h2D |=> linreg1_target_mv_o == 16'h0CB2)
    else $error("code 2D not 3.25 V");

  // every read strobe gets exactly one answer pulse on the next cycle
  a_read_valid_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_i.rd |=> rsp_o.valid)
    else $error("read strobe without answer");

  // no answer pulse without a read strobe before it
  a_no_stray_valid: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !req_i.rd |=> !rsp_o.valid)
    else $error("answer pulse without read");

  // offsets outside the bank answer zero
  a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_i.rd && req_i.addr != ALT_CODE_ADDR && req_i.addr != LIN1_CODE_ADDR |=> rsp_o.data == READ_ZERO)
    else $error("unmapped read nonzero");

  // a write to the alternate offset lands in the register on its edge
  a_alt_write_lands: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_alt_write |=> alt_code_q == $past(req_i.wdata))
    else $error("alternate code write lost");

  // without a write to its offset the alternate code keeps its value
  a_alt_code_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(req_i.wr && req_i.addr == ALT_CODE_ADDR) |=> $stable(alt_code_q))
    else $error("alternate code changed unasked");

  // without a write to its offset the linear code keeps its value
  a_lin_code_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(req_i.wr && req_i.addr == LIN1_CODE_ADDR) |=> $stable(lin1_code_q))
    else $error("linear code changed unasked");

  // alternate read shows the value held at the strobe, old value on a same-cycle write
  a_alt_read_data: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_i.rd && req_i.addr == ALT_CODE_ADDR |=> rsp_o.data == $past(alt_code_q))
    else $error("alternate read data wrong");

  // linear read shows zero spares above the stored code field
  a_lin_read_data: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_i.rd && req_i.addr == LIN1_CODE_ADDR |=> rsp_o.data == {LIN_SPARE_VALUE, $past(lin1_code_q)})
    else $error("linear read data wrong");

  // converter target never exceeds its ceiling
  a_conv_ceiling: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    converter_target_dmv_o <= CONV_MAX_DMV)
    else $error("converter target above ceiling");

  // linear target never exceeds its ceiling
  a_lin_ceiling: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    linreg1_target_mv_o <= LIN_MAX_MV)
    else $error("linear target above ceiling");

  // once decoding has run the converter target is at least the base
  a_conv_floor: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    init_done_q |-> converter_target_dmv_o >= CONV_BASE_DMV)
    else $error("converter target below base");

  // once decoding has run the linear target is at least the base
  a_lin_floor: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    init_done_q |-> linreg1_target_mv_o >= LIN_BASE_MV)
    else $error("linear target below base");

endmodule
`default_nettype wire

/* File: core/voltage_code_pkg.sv */
/*
  package for the regulator voltage-code register bank: register offsets,
  reset values, field layouts, decoder constants and the request carrier.
  assumes a serial control engine elsewhere in the device that turns bus
  frames into single-cycle register requests.
*/
package voltage_code_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] ALT_CODE_ADDR = 8'h41;  // converter alternate target code
  localparam logic [7:0] LIN1_CODE_ADDR = 8'h42; // first linear regulator code

  // reset values
  localparam logic [7:0] ALT_CODE_RESET = 8'h30;  // decodes to 1.2 V
  localparam logic [7:0] LIN1_CODE_RESET = 8'h10; // decodes to 1.8 V

  // linear regulator code field layout
  localparam int LIN_CODE_MSB = 5;                  // code field is bits 5..0
  localparam int LIN_CODE_W = LIN_CODE_MSB + 1;     // code field width
  localparam logic [1:0] LIN_SPARE_VALUE = 2'h0;    // spare bits 7..6 read zero

  // converter decoder, targets in units of 0.1 mV
  localparam logic [15:0] CONV_BASE_DMV = 16'h1770; // 0.6000 V at code zero
  localparam logic [15:0] CONV_STEP_DMV = 16'h007D; // 12.5 mV per code
  localparam logic [15:0] CONV_MAX_DMV = 16'h80E8;  // 3.3000 V ceiling
  localparam logic [7:0] CONV_CLAMP_CODE = 8'hD8;   // first clamped code

  // linear regulator decoder, targets in mV
  localparam logic [15:0] LIN_BASE_MV = 16'h03E8;   // 1.00 V at code zero
  localparam logic [15:0] LIN_STEP_MV = 16'h0032;   // 50 mV per code
  localparam logic [15:0] LIN_MAX_MV = 16'h0CE4;    // 3.30 V ceiling
  localparam logic [5:0] LIN_CLAMP_CODE = 6'h2E;    // first clamped code

  // zero data for unmapped reads
  localparam logic [7:0] READ_ZERO = 8'h00;

  // one register request from the serial control engine
  typedef struct packed {
    logic       wr;    // write strobe, one cycle
    logic       rd;    // read strobe, one cycle
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write data
  } reg_req_t;

  // read answer to the serial control engine
  typedef struct packed {
    logic       valid; // one-cycle pulse, read data valid
    logic [7:0] data;  // read data
  } reg_rsp_t;

  // converter code to 0.1 mV units, shared by normal and alternate codes
  function automatic logic [15:0] conv_decode(input logic [7:0] code);
    logic [15:0] t;
    t = CONV_BASE_DMV + ({8'h00, code} * CONV_STEP_DMV);
    return (code >= CONV_CLAMP_CODE) ? CONV_MAX_DMV : t;
  endfunction

  // linear regulator code to mV
  function automatic logic [15:0] lin_decode(input logic [5:0] code);
    logic [15:0] t;
    t = LIN_BASE_MV + ({10'h000, code} * LIN_STEP_MV);
    return (code >= LIN_CLAMP_CODE) ? LIN_MAX_MV : t;
  endfunction

endpackage

/* File: verification/reg_host_model.sv */
/*
  host model: issues single register writes and reads on the strobe port.
  assumes its tasks are called from the bench clocked by mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  // clock and read answer
  input wire logic mclk_i,
  input wire voltage_code_pkg::reg_rsp_t rsp_i,
  // register request
  output var voltage_code_pkg::reg_req_t req_o
);
  import voltage_code_pkg::*;
  // idle request from time zero
  initial req_o = '0;
  // one-cycle write strobe; released fields show inverted junk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one-cycle read strobe; answer taken while its valid pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    v = rsp_i.valid;
    d = rsp_i.data;
  endtask
  // write then read in the very next cycle; answer taken while its pulse stands
  task automatic wrrd(input logic [7:0] a, input logic [7:0] dw, output logic [7:0] d, output logic v);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dw};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    v = rsp_i.valid;
    d = rsp_i.data;
  endtask
endmodule
`default_nettype wire

/* File: verification/voltage_code_regs_test.sv */
/*
  self-checking bench for the voltage-code register bank.
  assumes the host model drives the register port and targets settle
  one cycle after a code or select change.
*/
`timescale 1ns/1ps
`default_nettype none
module voltage_code_regs_test;
  import voltage_code_pkg::*;
  logic mclk_i;
  logic rst_n_i;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [7:0] norm_code;
  logic sel;
  logic [15:0] conv_t;
  logic [15:0] lin_t;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h7F, 8'hD7, 8'hD8, 8'hFF};
  logic [7:0] lcodes [4] = '{8'hED, 8'h2E, 8'h3F, 8'hC0};
  initial mclk_i = 1'b0;
  always #10 mclk_i = ~mclk_i;
  voltage_code_regs voltage_code_regs_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp),
    .converter_normal_voltage_code_i(norm_code), .dynamic_voltage_scaling_sel_i(sel),
    .converter_target_dmv_o(conv_t), .linreg1_target_mv_o(lin_t));
  reg_host_model reg_host_model_i (.mclk_i(mclk_i), .rsp_i(rsp), .req_o(req));
  // expected targets: 0.1 mV and mV units
  function automatic logic [15:0] conv_exp(input logic [7:0] c);
    return (c < 8'hD8) ? 16'(6000 + 125 * c) : 16'd33000;
  endfunction
  function automatic logic [15:0] lin_exp(input logic [5:0] c);
    return (c < 6'h2E) ? 16'(1000 + 50 * c) : 16'd3300;
  endfunction
  // one comparison
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // read one register, expect a valid pulse and the given byte
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    reg_host_model_i.rd(a, d, v);
    chk({n, " valid"}, 16'h0001, {15'h0000, v});
    chk(n, {8'h00, e}, {8'h00, d});
  endtask
  // reset values and decoded reset targets
  task automatic t_reset();
    rdchk("alt code", ALT_CODE_ADDR, 8'h30);
    rdchk("lin1 code", LIN1_CODE_ADDR, 8'h10);
    @(posedge mclk_i) sel <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk("conv target", 16'd12000, conv_t);
    chk("lin1 target", 16'd1800, lin_t);
  endtask
  // alternate code sweep, select switching, shared decoder
  task automatic t_conv();
    foreach (codes[i]) begin
      @(posedge mclk_i) begin sel <= 1'b1; norm_code <= ~codes[i]; end
      reg_host_model_i.wr(ALT_CODE_ADDR, codes[i]);
      rdchk("alt readback", ALT_CODE_ADDR, codes[i]);
      chk("alt target", conv_exp(codes[i]), conv_t);
      @(posedge mclk_i) begin sel <= 1'b0; norm_code <= codes[i]; end
      @(posedge mclk_i);
      #1;
      chk("normal target", conv_exp(codes[i]), conv_t);
    end
  endtask
  // linear code with spare bits set, clamp codes
  task automatic t_lin();
    foreach (lcodes[i]) begin
      reg_host_model_i.wr(LIN1_CODE_ADDR, lcodes[i]);
      rdchk("lin1 readback", LIN1_CODE_ADDR, lcodes[i] & 8'h3F);
      chk("lin1 target", lin_exp(lcodes[i][5:0]), lin_t);
    end
  endtask
  // unmapped write ignored, unmapped read answers zero
  task automatic t_unmapped();
    logic [7:0] d;
    logic v;
    reg_host_model_i.wr(8'h43, 8'h55);
    rdchk("unmapped", 8'h43, READ_ZERO);
    rdchk("alt kept", ALT_CODE_ADDR, 8'hFF);
    reg_host_model_i.wrrd(ALT_CODE_ADDR, 8'h5A, d, v);
    chk("alt back to back valid", 16'h0001, {15'h0000, v});
    chk("alt back to back", 16'h005A, {8'h00, d});
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    sel = 1'b0;
    norm_code = 8'h30;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_conv();
    t_lin();
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire
